/* pkg/adc_seq_map.svh */
/*
  offsets, field positions, reset values and timing counts of the
  conversion sequencer; assumes a 32-bit APB slave with byte addresses.
*/
// How it works
// - fixed mode converts the one input picked by the channel field
// - scan mode walks AN0 or AN4 upward to the picked channel
// - after reset scan is off and channel field is zero
// - start by writing the start bit or by enabled trigger falling edge
// - busy flag goes high at start and stays while converting
// - writing start during a conversion restarts it
// - trigger falling edges are ignored while a conversion runs
// - repeat and scan bits together pick one of four modes
// - single modes run once, then set end flag, clear busy, interrupt
// - fixed repeat sets end each time, interrupt each or every fourth
// - scan repeat rescans, end flag and interrupt per scan, busy held
// - clearing repeat ends after the current conversion and clears busy
// - halt stops at once; repeat restarts on release, single stays idle
// - one channel takes 84 states
// - outside fixed repeat results go to the pair of their channel
// - fixed repeat fills pairs 0 to 3 in turn and wraps
// - storage flag set on store, cleared by reading either pair register
// - reading any result clears the end flag
// - result registers are read only
// - upper holds bits 9..2; lower holds bits 1..0, ones, flag
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
`define OFS_MODE0 8'h00
`define OFS_MODE1 8'h04
`define OFS_RES_BASE 8'h08
`define M0_CONV_END_FLAG 7
`define M0_BUSY 6
`define M0_ITM 3
`define M0_RPT 2
`define M0_SCAN 1
`define M0_START 0
`define M1_REF 7
`define M1_IDLE 6
`define M1_TRGE 3
`define M0_RST 4'h0
`define M1_RST 6'h00
`define LOW_ONES 5'h1f
`define CONV_STATES 84
`define FOURTH_CNT 2'h3
`endif

/* pkg/adc_seq_pkg.sv */
/*
  types of the conversion sequencer: states, mode fields, state record;
  assumes adc_seq_map.svh for the numbers.
*/
package adc_seq_pkg;

   // sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_HALT = 3'b100
   } seq_state_t;

   // software fields of mode control 0
   typedef struct packed {
      logic end_flag;
      logic itm;
      logic rpt;
      logic scan;
   } mode0_t;

   // software fields of mode control 1
   typedef struct packed {
      logic ref_en;
      logic idle_run;
      logic trg_en;
      logic [2:0] ch;
   } mode1_t;

   // whole state of the sequencer top
   typedef struct packed {
      seq_state_t fsm;
      mode0_t m0;
      mode1_t m1;
      logic busy;
      logic [2:0] cur;
      logic [1:0] ptr;
      logic [1:0] icnt;
      logic run_rpt;
      logic trg_prev;
      logic [3:0] stored;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } seq_reg_t;

endpackage

/* rtl/conv_timer.sv */
/*
  counts the states of one channel conversion and pulses done;
  assumes one state per clock cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"
module conv_timer #(
   parameter int STATES = `CONV_STATES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic start,
   input wire logic stop,
   output logic done
);
   typedef struct packed {
      logic run;
      logic [7:0] cnt;
      logic done;
   } tmr_t;
   tmr_t s_reg, s_next;

   if (STATES < 2 || STATES > 255) begin : g_bad_states
      $error("conv_timer: STATES out of range");
   end

   // start wins over running, stop wins over all
   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      if (stop) begin
         s_next.run = 1'b0;
      end else if (start) begin
         s_next.run = 1'b1;
         s_next.cnt = 8'h00;
      end else if (s_reg.run) begin
         if (s_reg.cnt == 8'(STATES - 2)) begin
            s_next.run = 1'b0;
            s_next.done = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) s_reg <= '0;
      else s_reg <= s_next;
   end

   assign done = s_reg.done;
endmodule // conv_timer
`default_nettype wire

/* rtl/result_mem.sv */
/*
  small result store, one write and one registered read port;
  assumes the caller keeps the storage flags.
*/
`timescale 1ns/1ps
`default_nettype none
module result_mem #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] rdata;
   } mem_t;
   mem_t s_reg, s_next;

   if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
      $error("result_mem: size not served");
   end

   // read takes old contents, write lands the same edge
   always_comb begin
      s_next = s_reg;
      s_next.rdata = s_reg.mem[raddr];
      if (we) s_next.mem[waddr] = wdata;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) s_reg <= '0;
      else s_reg <= s_next;
   end

   assign rdata = s_reg.rdata;
endmodule // result_mem
`default_nettype wire

/* rtl/adc_conversion_sequencer.sv */
/*
  control of a 10-bit successive approximation converter with eight
  inputs: mode registers, channel sequencing, result pairs, end pulse.
  assumes an APB master, a comparator that presents a settled code on
  adc_code when a channel's 84 states are over, and halt levels from
  the power manager.
*/
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"
module adc_conversion_sequencer #(
   parameter int RES_W = 10,
   parameter int PAIRS = 4
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_trigger_pin,
   input wire logic light_idle_state,
   input wire logic deep_idle_state,
   input wire logic [9:0] adc_code,
   output logic [2:0] analog_channel,
   output logic comparator_run,
   output logic ref_ladder_enable,
   output logic conv_busy_flag,
   output logic conv_end_irq
);

   if (RES_W != 10 || PAIRS != 4) begin : g_bad_param
      $error("adc_conversion_sequencer: only 10 bits and 4 pairs served");
   end

   ////////////////////////////////////////////////////////////////////
   // register index decode

   localparam logic [3:0] IDX_M0 = 4'h0;
   localparam logic [3:0] IDX_M1 = 4'h1;
   localparam logic [3:0] IDX_NONE = 4'hf;

   // 0 mode0, 1 mode1, 2..9 result low/high by pair, 15 unmapped
   function automatic logic [3:0] reg_index(input logic [7:0] a);
      logic [7:0] rel;
      rel = a - `OFS_RES_BASE;
      reg_index = IDX_NONE;
      if (a[1:0] != 2'b00) reg_index = IDX_NONE;
      else if (a == `OFS_MODE0) reg_index = IDX_M0;
      else if (a == `OFS_MODE1) reg_index = IDX_M1;
      else if (a >= `OFS_RES_BASE && rel < 8'h20) begin
         reg_index = 4'(rel[7:2]) + 4'h2;
      end
   endfunction

   // true for a result register index
   function automatic logic is_result(input logic [3:0] i);
      is_result = (i >= 4'h2) && (i <= 4'h9);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // state, timer and result store

   adc_seq_pkg::seq_reg_t s_reg, s_next;
   logic t_start;
   logic t_stop;
   logic t_done;
   logic m_we;
   logic [1:0] m_waddr;
   logic [9:0] m_rdata;
   logic [3:0] idx;
   logic [1:0] rpair;

   assign idx = reg_index(paddr);
   assign rpair = 2'((idx - 4'h2) >> 1); // low and high word of a pair share it

   conv_timer #(
      .STATES(`CONV_STATES)
   ) u_timer (
      .clock(clock),
      .rst_b(rst_b),
      .start(t_start),
      .stop(t_stop),
      .done(t_done)
   );

   result_mem #(
      .WIDTH(RES_W),
      .DEPTH(PAIRS)
   ) u_mem (
      .clock(clock),
      .rst_b(rst_b),
      .we(m_we),
      .waddr(m_waddr),
      .wdata(adc_code),
      .raddr(rpair),
      .rdata(m_rdata)
   );

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic done_xfer;
      logic wr;
      logic rd;
      logic start_sw;
      logic trg_fall;
      logic hw_trig;
      logic halt;
      logic fixed_rpt;
      logic last;
      logic stopping;
      logic begin_seq;
      logic [2:0] first;
      logic [31:0] rmux;
      done_xfer = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      start_sw = 1'b0;
      trg_fall = 1'b0;
      hw_trig = 1'b0;
      halt = 1'b0;
      fixed_rpt = 1'b0;
      last = 1'b0;
      stopping = 1'b0;
      begin_seq = 1'b0;
      first = 3'h0;
      rmux = 32'h0000_0000;
      s_next = s_reg;
      s_next.irq = 1'b0;
      t_start = 1'b0;
      t_stop = 1'b0;
      m_we = 1'b0;
      m_waddr = 2'h0;

      // apb: one wait state, then the transfer completes
      done_xfer = psel && penable && s_reg.pready;
      wr = done_xfer && pwrite;
      rd = done_xfer && !pwrite;
      s_next.pready = psel && penable && !s_reg.pready;

      // read data captured one cycle before the completing edge
      case (idx)
         IDX_M0: begin
            rmux[`M0_CONV_END_FLAG] = s_reg.m0.end_flag;
            rmux[`M0_BUSY] = s_reg.busy;
            rmux[`M0_ITM] = s_reg.m0.itm;
            rmux[`M0_RPT] = s_reg.m0.rpt;
            rmux[`M0_SCAN] = s_reg.m0.scan;
         end
         IDX_M1: begin
            rmux[`M1_REF] = s_reg.m1.ref_en;
            rmux[`M1_IDLE] = s_reg.m1.idle_run;
            rmux[`M1_TRGE] = s_reg.m1.trg_en;
            rmux[2:0] = s_reg.m1.ch;
         end
         default: begin
            if (is_result(idx) && !idx[0]) begin
               rmux[7:0] = {m_rdata[1:0], `LOW_ONES, s_reg.stored[rpair]};
            end else if (is_result(idx)) begin
               rmux[7:0] = m_rdata[9:2];
            end
         end
      endcase
      if (s_next.pready) begin
         s_next.prdata = rmux;
         s_next.pslverr = (idx == IDX_NONE);
      end

      // software writes; result registers take none
      if (wr && idx == IDX_M0) begin
         s_next.m0.itm = pwdata[`M0_ITM];
         s_next.m0.rpt = pwdata[`M0_RPT];
         s_next.m0.scan = pwdata[`M0_SCAN];
         start_sw = pwdata[`M0_START];
      end
      if (wr && idx == IDX_M1) begin
         s_next.m1.ref_en = pwdata[`M1_REF];
         s_next.m1.idle_run = pwdata[`M1_IDLE];
         s_next.m1.trg_en = pwdata[`M1_TRGE];
         s_next.m1.ch = pwdata[2:0];
      end

      // reading a result clears its pair flag and the end flag
      if (rd && is_result(idx)) begin
         s_next.stored[rpair] = 1'b0;
         s_next.m0.end_flag = 1'b0;
      end

      // trigger edge only counts when enabled and idle
      s_next.trg_prev = ext_trigger_pin;
      trg_fall = s_reg.trg_prev && !ext_trigger_pin;
      hw_trig = s_reg.m1.trg_en && trg_fall && !s_reg.busy;

      // halt: deep idle always, light idle unless allowed to run
      halt = deep_idle_state || (light_idle_state && !s_reg.m1.idle_run);

      // first channel of a sequence
      first = s_next.m0.scan ? {s_next.m1.ch[2], 2'b00} : s_next.m1.ch;
      fixed_rpt = s_reg.run_rpt && !s_reg.m0.scan;
      last = !s_reg.m0.scan || (s_reg.cur[1:0] == s_reg.m1.ch[1:0])
         || (s_reg.cur[1:0] == 2'b11);
      stopping = s_reg.run_rpt && !s_reg.m0.rpt;

      case (s_reg.fsm)
         adc_seq_pkg::ST_IDLE: begin
            if (!halt && (start_sw || hw_trig)) begin_seq = 1'b1;
         end
         adc_seq_pkg::ST_CONV: begin
            if (halt) begin
               t_stop = 1'b1;
               if (s_reg.run_rpt) begin
                  s_next.fsm = adc_seq_pkg::ST_HALT;
               end else begin
                  s_next.fsm = adc_seq_pkg::ST_IDLE;
                  s_next.busy = 1'b0;
               end
            end else if (start_sw) begin
               begin_seq = 1'b1;
            end else if (t_done) begin
               // store result in its channel's pair, or in pair ptr in fixed repeat
               m_we = 1'b1;
               m_waddr = fixed_rpt ? s_reg.ptr : s_reg.cur[1:0];
               if (fixed_rpt) s_next.ptr = s_reg.ptr + 2'h1;
               if (!last && !stopping) begin
                  s_next.cur = {s_reg.cur[2], s_reg.cur[1:0] + 2'h1};
                  t_start = 1'b1;
               end else begin
                  s_next.m0.end_flag = 1'b1;
                  if (!s_reg.run_rpt || stopping) begin
                     s_next.irq = 1'b1;
                     s_next.busy = 1'b0;
                     s_next.fsm = adc_seq_pkg::ST_IDLE;
                  end else begin
                     s_next.icnt = s_reg.icnt + 2'h1;
                     s_next.irq = s_reg.m0.scan || !s_reg.m0.itm
                        || (s_reg.icnt == `FOURTH_CNT);
                     s_next.cur = first;
                     t_start = 1'b1;
                  end
               end
            end
         end
         adc_seq_pkg::ST_HALT: begin
            if (!halt) begin_seq = 1'b1;
         end
         default: begin
            s_next.fsm = adc_seq_pkg::ST_IDLE;
            s_next.busy = 1'b0;
         end
      endcase

      // begin a sequence from its first channel
      if (begin_seq) begin
         s_next.fsm = adc_seq_pkg::ST_CONV;
         s_next.busy = 1'b1;
         s_next.cur = first;
         s_next.ptr = 2'h0;
         s_next.icnt = 2'h0;
         s_next.run_rpt = s_next.m0.rpt;
         t_start = 1'b1;
      end

      // a store in the same cycle as a read keeps the flag set
      if (m_we) s_next.stored[m_waddr] = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         s_reg <= '{fsm: adc_seq_pkg::ST_IDLE, default: '0};
         s_reg.m0 <= `M0_RST;
         s_reg.m1 <= `M1_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all straight from flops

   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign analog_channel = s_reg.cur;
   assign comparator_run = s_reg.fsm[1];
   assign ref_ladder_enable = s_reg.m1.ref_en;
   assign conv_busy_flag = s_reg.busy;
   assign conv_end_irq = s_reg.irq;

endmodule // adc_conversion_sequencer
`default_nettype wire

/* tb/adc_far_side.sv */
/* far side of the sequencer: analog code per channel and trigger source.
   assumes the bench toggles trig_req to ask for one trigger pulse. */
`timescale 1ns/1ps
`default_nettype none
module adc_far_side (
   input wire logic clock,
   input wire logic [2:0] analog_channel,
   input wire logic comparator_run,
   input wire logic trig_req,
   output logic [9:0] adc_code,
   output logic ext_trigger_pin
);
   logic req_q = 1'b0;
   logic [1:0] low = 2'h0;
   logic [9:0] lvl;
   // settled code while converting, inverted while the comparator rests
   assign lvl = {analog_channel, analog_channel, analog_channel, 1'b1};
   assign adc_code = comparator_run ? lvl : ~lvl;
   // three-cycle low pulse per request; the pin idles high
   always_ff @(posedge clock) begin
      req_q <= trig_req;
      if (trig_req != req_q) low <= 2'h3;
      else if (low != 2'h0) low <= low - 2'h1;
   end
   assign ext_trigger_pin = (low == 2'h0);
endmodule // adc_far_side
`default_nettype wire

/* tb/adc_seq_properties.sv */
/* port checker of the sequencer: start, timing, channels, result words.
   assumes a bind to the sequencer top and a single clock. */
`timescale 1ns/1ps
`default_nettype none
module adc_seq_properties (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ext_trigger_pin,
   input wire logic light_idle_state,
   input wire logic deep_idle_state,
   input wire logic [9:0] adc_code,
   input wire logic [2:0] analog_channel,
   input wire logic comparator_run,
   input wire logic ref_ladder_enable,
   input wire logic conv_busy_flag,
   input wire logic conv_end_irq
);
   logic [7:0] m1, since;
   logic [1:0] m0, pair;
   logic [3:0] rd_seen;
   logic cap_fs, trg_q, wr_done, rd_done, start_wr, halted, trg_st, res_rd;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   // bus events, halt and trigger start
   assign wr_done = psel && penable && pready && pwrite;
   assign rd_done = psel && penable && pready && !pwrite;
   assign start_wr = wr_done && paddr == 8'h00 && pwdata[0];
   assign halted = deep_idle_state || (light_idle_state && !m1[6]);
   assign res_rd = rd_done && paddr >= 8'h08 && paddr <= 8'h24 && !pslverr;
   assign pair = paddr[4:3] - 2'h1;
   assign trg_st = trg_q && !ext_trigger_pin && m1[3] && !conv_busy_flag && !halted;
   // mode copies, cycles since start, reads since the last conversion
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         m1 <= 8'h00;
         m0 <= 2'h0;
         since <= 8'hff;
         cap_fs <= 1'b0;
         rd_seen <= 4'h0;
         trg_q <= 1'b1;
      end else begin
         trg_q <= ext_trigger_pin;
         if (wr_done && paddr == 8'h04) m1 <= pwdata[7:0];
         if (wr_done && paddr == 8'h00) m0 <= pwdata[2:1];
         if ((start_wr && !halted) || trg_st) since <= 8'h01;
         else if (since != 8'hff) since <= since + 8'h01;
         if (halted) cap_fs <= 1'b0;
         else if (start_wr) cap_fs <= (pwdata[2:1] == 2'h0);
         else if (trg_st) cap_fs <= (m0 == 2'h0);
         if (comparator_run) rd_seen <= 4'h0;
         else if (res_rd) rd_seen[pair] <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_busy_run;
      cap_fs && since < 8'd85 |-> conv_busy_flag && !conv_end_irq;
   endproperty
   a_busy_run: assert property (p_busy_run) else $error("busy lost early");
   property p_single_done;
      cap_fs && since == 8'd85 |-> conv_end_irq && !conv_busy_flag;
   endproperty
   a_single_done: assert property (p_single_done) else $error("end late");
   property p_trg_start;
      trg_st |=> conv_busy_flag;
   endproperty
   a_trg_start: assert property (p_trg_start) else $error("trigger no start");
   property p_fixed_ch;
      cap_fs && comparator_run |-> analog_channel == m1[2:0];
   endproperty
   a_fixed_ch: assert property (p_fixed_ch) else $error("wrong fixed input");
   property p_scan_first;
      start_wr && pwdata[1] && !halted |=> comparator_run && analog_channel == {m1[2], 2'b00};
   endproperty
   a_scan_first: assert property (p_scan_first) else $error("scan first wrong");
   property p_scan_step;
      comparator_run && m0[0] |-> analog_channel[2] == m1[2] && analog_channel[1:0] <= m1[1:0];
   endproperty
   a_scan_step: assert property (p_scan_step) else $error("scan range wrong");
   property p_irq_pulse;
      conv_end_irq |=> !conv_end_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
   property p_halt;
      halted |=> !comparator_run;
   endproperty
   a_halt: assert property (p_halt) else $error("runs in halt");
   property p_low_ones;
      res_rd && !paddr[2] |-> prdata[5:1] == 5'h1f && prdata[31:8] == 24'h0;
   endproperty
   a_low_ones: assert property (p_low_ones) else $error("low word form");
   property p_flag_clr;
      res_rd && !paddr[2] && rd_seen[pair] |-> !prdata[0];
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag kept");
   cover property (start_wr && pwdata[1]);
   cover property (trg_st);
   cover property (halted && conv_busy_flag);
endmodule // adc_seq_properties
bind adc_conversion_sequencer adc_seq_properties chk (.clock(clock), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_trigger_pin(ext_trigger_pin),
   .light_idle_state(light_idle_state), .deep_idle_state(deep_idle_state),
   .adc_code(adc_code), .analog_channel(analog_channel), .comparator_run(comparator_run),
   .ref_ladder_enable(ref_ladder_enable), .conv_busy_flag(conv_busy_flag),
   .conv_end_irq(conv_end_irq));
`default_nettype wire

/* tb/tb_top.sv */
/* self-checking bench of the sequencer over APB with the far-side model.
   assumes the checker is bound to the top and one wait state per transfer. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic light_idle_state = 1'b0, deep_idle_state = 1'b0, trig_req = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, ext_trigger_pin, comparator_run, ref_ladder_enable;
   logic conv_busy_flag, conv_end_irq;
   logic [9:0] adc_code;
   logic [2:0] analog_channel, c;
   typedef struct {logic [32:0] v; logic [31:0] m;} note_t;
   note_t notes[$];
   note_t nt;
   int n_mismatch = 0, checks = 0, seed = 39, n, r;
   always #10 clock = ~clock;
   adc_conversion_sequencer uut (.clock(clock), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_trigger_pin(ext_trigger_pin),
      .light_idle_state(light_idle_state), .deep_idle_state(deep_idle_state),
      .adc_code(adc_code), .analog_channel(analog_channel), .comparator_run(comparator_run),
      .ref_ladder_enable(ref_ladder_enable), .conv_busy_flag(conv_busy_flag),
      .conv_end_irq(conv_end_irq));
   adc_far_side far (.clock(clock), .analog_channel(analog_channel),
      .comparator_run(comparator_run), .trig_req(trig_req), .adc_code(adc_code),
      .ext_trigger_pin(ext_trigger_pin));
   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [32:0] seen, input logic [32:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task chk1(input logic seen, input logic exp, input string what);
      check({32'h0, seen}, {32'h0, exp}, what);
   endtask
   task end_sim;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one APB transfer, held until pready is seen at a falling edge
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(negedge clock); while (pready !== 1'b1);
      @(posedge clock);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m, input logic e);
      notes.push_back('{{e, v}, m});
      xfer(1'b0, a, 32'h0);
   endtask
   task pair_chk(input logic [2:0] ch, input logic [1:0] p, input logic f);
      rd(8'h08 + 8'({p, 3'b000}), {24'h0, ch[0], 6'h3f, f}, '1, 1'b0);
      rd(8'h0c + 8'({p, 3'b000}), {24'h0, ch, ch, ch[2:1]}, '1, 1'b0);
   endtask
   task wirq(input int lim);
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (conv_end_irq !== 1'b1 && n < lim);
      chk1(conv_end_irq, 1'b1, "irq");
   endtask
   // read monitor: oldest note against the answer
   always @(posedge clock) if (psel && penable && pready === 1'b1 && !pwrite) begin
      nt = notes.pop_front();
      check({pslverr, prdata & nt.m}, nt.v, "prdata");
   end
   initial begin
      #(40000 * 20);
      n_mismatch++;
      end_sim;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      rd(8'h00, 32'h0, 32'hff, 1'b0);
      rd(8'h04, 32'h0, 32'hff, 1'b0);
      rd(8'h28, 32'h0, '1, 1'b1);
      xfer(1'b1, 8'h04, 32'h80);
      repeat (150) @(negedge clock);
      chk1(ref_ladder_enable, 1'b1, "ref");
      r = $random(seed);
      // fixed single over every channel code
      for (int i = 0; i < 8; i++) begin
         c = 3'(i + r);
         xfer(1'b1, 8'h04, {24'h0, 5'h10, c});
         xfer(1'b1, 8'h00, 32'h1);
         wirq(100);
         rd(8'h00, 32'h80, 32'hc0, 1'b0);
         pair_chk(c, c[1:0], 1'b1);
         xfer(1'b1, 8'h08 + 8'({c[1:0], 3'b000}), $random(seed));
         rd(8'h08 + 8'({c[1:0], 3'b000}), {24'h0, c[0], 7'h7e}, '1, 1'b0);
         rd(8'h00, 32'h0, 32'hc0, 1'b0);
      end
      // scan single over every sequence
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         xfer(1'b1, 8'h04, {24'h0, 5'h10, c});
         xfer(1'b1, 8'h00, 32'h3);
         wirq(400);
         rd(8'h00, 32'h80, 32'hc0, 1'b0);
         for (int k = 4 * c[2]; k <= c; k++) pair_chk(3'(k), 2'(k), 1'b1);
      end
      // fixed repeat, interrupt on each and on every fourth
      xfer(1'b1, 8'h04, 32'h85);
      xfer(1'b1, 8'h00, 32'h5);
      repeat (4) begin
         wirq(100);
         chk1(conv_busy_flag, 1'b1, "busy");
      end
      for (int k = 0; k < 4; k++) rd(8'(8 + 8 * k), 32'hff, '1, 1'b0);
      xfer(1'b1, 8'h00, 32'h0);
      wirq(100);
      chk1(conv_busy_flag, 1'b0, "busy");
      xfer(1'b1, 8'h00, 32'hd);
      wirq(400);
      wirq(400);
      check(33'(n), 33'd336, "interval");
      xfer(1'b1, 8'h00, 32'h0);
      wirq(100);
      // scan repeat, halt early in the first channel of a scan, restart from the start
      xfer(1'b1, 8'h04, 32'h86);
      xfer(1'b1, 8'h00, 32'h7);
      wirq(300);
      wirq(300);
      check(33'(n), 33'd252, "interval");
      chk1(conv_busy_flag, 1'b1, "busy");
      @(posedge clock);
      deep_idle_state <= 1'b1;
      repeat (10) @(negedge clock);
      chk1(comparator_run, 1'b0, "run");
      chk1(conv_busy_flag, 1'b1, "busy");
      @(posedge clock);
      deep_idle_state <= 1'b0;
      wirq(300);
      chk1(n >= 252, 1'b1, "restart");
      xfer(1'b1, 8'h00, 32'h0);
      wirq(100);
      chk1(conv_busy_flag, 1'b0, "busy");
      // single stopped by light idle stays stopped
      xfer(1'b1, 8'h04, 32'h81);
      xfer(1'b1, 8'h00, 32'h1);
      repeat (20) @(posedge clock);
      light_idle_state <= 1'b1;
      repeat (5) @(negedge clock);
      chk1(conv_busy_flag, 1'b0, "busy");
      @(posedge clock);
      light_idle_state <= 1'b0;
      repeat (100) @(negedge clock);
      chk1(conv_busy_flag, 1'b0, "busy");
      // restart by a second start write
      xfer(1'b1, 8'h00, 32'h1);
      repeat (40) @(posedge clock);
      xfer(1'b1, 8'h00, 32'h1);
      wirq(100);
      chk1(n > 70, 1'b1, "restart");
      pair_chk(3'h1, 2'h1, 1'b1);
      // trigger start, edge while busy ignored, edge with the trigger disabled ignored
      xfer(1'b1, 8'h04, 32'h88);
      trig_req <= ~trig_req;
      repeat (30) @(posedge clock);
      trig_req <= ~trig_req;
      wirq(100);
      chk1(n < 70, 1'b1, "trigger");
      xfer(1'b1, 8'h04, 32'h80);
      trig_req <= ~trig_req;
      repeat (10) @(negedge clock);
      chk1(conv_busy_flag, 1'b0, "busy");
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      rd(8'h04, 32'h0, 32'hff, 1'b0);
      end_sim;
   end
endmodule // tb_top
`default_nettype wire
